// ==== core/cpu_regs_pkg.sv ====
`default_nettype none
package cpu_regs_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W = 16;
  localparam int LONG_W = 20;
  localparam int FLG_W  = 11;

  // ****************************************************************
  // Register offsets (byte addresses in bus space)
  // ****************************************************************
  localparam logic [7:0] OFS_DATA0   = 8'h00;
  localparam logic [7:0] OFS_DATA1   = 8'h04;
  localparam logic [7:0] OFS_DATA2   = 8'h08;
  localparam logic [7:0] OFS_DATA3   = 8'h0C;
  localparam logic [7:0] OFS_ADDR0   = 8'h10;
  localparam logic [7:0] OFS_ADDR1   = 8'h14;
  localparam logic [7:0] OFS_FRAME   = 8'h18;
  localparam logic [7:0] OFS_VECTAB  = 8'h1C;
  localparam logic [7:0] OFS_PC      = 8'h20;
  localparam logic [7:0] OFS_USR_SP  = 8'h24;
  localparam logic [7:0] OFS_INT_SP  = 8'h28;
  localparam logic [7:0] OFS_STATIC  = 8'h2C;
  localparam logic [7:0] OFS_FLAGS   = 8'h30;
  localparam logic [7:0] OFS_STACK   = 8'h34;
  localparam logic [7:0] OFS_PAIR_D0 = 8'h38;
  localparam logic [7:0] OFS_PAIR_D1 = 8'h3C;
  localparam logic [7:0] OFS_PAIR_A  = 8'h40;

  // ****************************************************************
  // Flag bit positions
  // ****************************************************************
  localparam int FL_CARRY = 0;
  localparam int FL_DEBUG = 1;
  localparam int FL_ZERO  = 2;
  localparam int FL_SIGN  = 3;
  localparam int FL_BANK  = 4;
  localparam int FL_OVF   = 5;
  localparam int FL_IEN   = 6;
  localparam int FL_USEL  = 7;
  localparam int FL_PRI   = 8;
  localparam int PRI_W    = 3;
  localparam logic [FLG_W-1:0] FLG_RESET = 11'h000;
  localparam logic [FLG_W-1:0] FLG_WMASK = 11'h7FF;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [19:0] LONG_RESET = 20'h00000;
  localparam logic [5:0] SWI_LOW_LAST = 6'h1F;

  // ****************************************************************
  // Core-side carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    SEL_NONE, SEL_D0, SEL_D1, SEL_D2, SEL_D3, SEL_AD0, SEL_AD1, SEL_FRAME,
    SEL_STATIC, SEL_SP, SEL_PAIR_D0, SEL_PAIR_D1, SEL_PAIR_A
  } reg_sel_t;

  typedef struct packed {
    reg_sel_t    sel;
    logic [1:0]  lanes;
    logic [31:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic       upd_c;
    logic       upd_z;
    logic       upd_s;
    logic       upd_o;
    logic       c;
    logic       o;
    logic [31:0] result;
    logic       wide;
  } alu_flags_t;

  typedef struct packed {
    logic       hw_accept;
    logic       sw_accept;
    logic [5:0] sw_num;
    logic [2:0] new_pri;
  } irq_accept_t;

endpackage
`default_nettype wire

// ==== core/cpu_register_set.sv ====
`default_nettype none

// Summary of operation
// - Thirteen registers; data, address and frame base exist in two banks.
// - Data registers are 16 bits with separately writable byte halves.
// - Data 2:0 and 3:1 pair into 32-bit registers, first named upper.
// - Address registers 16 bits, pairable as one 32-bit register.
// - Frame base is 16 bits and feeds frame-relative addressing.
// - Vector table base is 20 bits, start of the vector table.
// - Program counter is 20 bits, address of next instruction.
// - Separate user and interrupt stack pointers; flag picks the active one.
// - Static base is 16 bits and feeds static-relative addressing.
// - Flag register is 11 bits showing processor status.
// - Carry flag captures carry, borrow or shifted-out bit.
// - Zero flag set on zero result, cleared otherwise.
// - Sign flag set on negative result, cleared otherwise.
// - Bank flag selects banked copy 0 or 1.
// - Overflow flag follows operation overflow.
// - Interrupt enable gates maskable interrupts; cleared on acceptance.
// - Stack select 0 picks interrupt pointer, 1 picks user pointer.
// - Stack select cleared on hardware interrupt or low software interrupt.
// - Priority level is three bits, levels 0 to 7.
// - Request enabled only when its priority exceeds the current level.
// - Reserved flag bits written 0; reads ignored.
module cpu_register_set
  import cpu_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  // Wishbone slave
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  input  wire logic                      WB_WE_I,
  input  wire logic [7:0]                WB_ADR_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic [31:0]               WB_DAT_I,
  output logic      [31:0]               WB_DAT_O,
  output logic                           WB_ACK_O,
  output logic                           WB_ERR_O,
  // Execution datapath
  input  wire cpu_regs_pkg::reg_wr_t     REG_WR,
  input  wire cpu_regs_pkg::reg_sel_t    REG_RD_SEL,
  output logic      [31:0]               REG_RD_DATA,
  input  wire cpu_regs_pkg::alu_flags_t  ALU_FLAGS,
  input  wire logic                      PC_LOAD,
  input  wire logic [19:0]               PC_NEXT,
  // Interrupt acceptance
  input  wire cpu_regs_pkg::irq_accept_t IRQ_ACCEPT,
  input  wire logic                      IRQ_REQ,
  input  wire logic                      IRQ_MASKABLE,
  input  wire logic [2:0]                IRQ_PRI,
  output logic                           IRQ_ENABLED,
  // Addressing bases, program counter and flags
  output logic      [15:0]               FRAME_BASE,
  output logic      [15:0]               STATIC_BASE,
  output logic      [15:0]               STACK_PTR,
  output logic      [19:0]               VECTOR_BASE,
  output logic      [19:0]               PROG_COUNTER,
  output logic      [cpu_regs_pkg::FLG_W-1:0] STATUS_FLAGS
);
  import cpu_regs_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0]      data_ff  [2][4];
  logic [15:0]      addr_ff  [2][2];
  logic [15:0]      frame_ff [2];
  logic [19:0]      vectab_ff;
  logic [19:0]      pc_ff;
  logic [15:0]      usr_sp_ff;
  logic [15:0]      int_sp_ff;
  logic [15:0]      static_ff;
  logic [FLG_W-1:0] flags_ff;
  logic             ack_ff;
  logic             err_ff;
  logic [31:0]      rdata_ff;

  logic             bank;
  logic             bus_req;
  logic             bus_wr;
  logic             bus_hit;
  reg_wr_t          bus_wdesc;
  logic             bus_flg_wr;
  logic             bus_usr_sp_wr;
  logic             bus_int_sp_wr;
  logic             bus_vec_wr;
  logic             bus_pc_wr;
  logic [31:0]      bus_rdata;

  assign bank = flags_ff[FL_BANK];

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] lanes);
    merge16 = {lanes[1] ? nw[15:8] : old[15:8], lanes[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic [31:0] read_sel(input reg_sel_t s, input logic b);
    case (s)
      SEL_D0:      read_sel = {16'h0000, data_ff[b][0]};
      SEL_D1:      read_sel = {16'h0000, data_ff[b][1]};
      SEL_D2:      read_sel = {16'h0000, data_ff[b][2]};
      SEL_D3:      read_sel = {16'h0000, data_ff[b][3]};
      SEL_AD0:     read_sel = {16'h0000, addr_ff[b][0]};
      SEL_AD1:     read_sel = {16'h0000, addr_ff[b][1]};
      SEL_FRAME:   read_sel = {16'h0000, frame_ff[b]};
      SEL_STATIC:  read_sel = {16'h0000, static_ff};
      SEL_SP:      read_sel = {16'h0000, flags_ff[FL_USEL] ? usr_sp_ff : int_sp_ff};
      SEL_PAIR_D0: read_sel = {data_ff[b][2], data_ff[b][0]};
      SEL_PAIR_D1: read_sel = {data_ff[b][3], data_ff[b][1]};
      SEL_PAIR_A:  read_sel = {addr_ff[b][1], addr_ff[b][0]};
      default:     read_sel = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff && !err_ff;
  assign bus_wr  = bus_req && WB_WE_I;

  always_comb begin
    bus_hit         = 1'b1;
    bus_wdesc.sel   = SEL_NONE;
    bus_wdesc.lanes = WB_SEL_I[1:0];
    bus_wdesc.data  = WB_DAT_I;
    bus_flg_wr      = 1'b0;
    bus_usr_sp_wr   = 1'b0;
    bus_int_sp_wr   = 1'b0;
    bus_vec_wr      = 1'b0;
    bus_pc_wr       = 1'b0;
    bus_rdata       = 32'h0000_0000;
    case (WB_ADR_I)
      OFS_DATA0:   bus_wdesc.sel = SEL_D0;
      OFS_DATA1:   bus_wdesc.sel = SEL_D1;
      OFS_DATA2:   bus_wdesc.sel = SEL_D2;
      OFS_DATA3:   bus_wdesc.sel = SEL_D3;
      OFS_ADDR0:   bus_wdesc.sel = SEL_AD0;
      OFS_ADDR1:   bus_wdesc.sel = SEL_AD1;
      OFS_FRAME:   bus_wdesc.sel = SEL_FRAME;
      OFS_STATIC:  bus_wdesc.sel = SEL_STATIC;
      OFS_STACK:   bus_wdesc.sel = SEL_SP;
      OFS_PAIR_D0: bus_wdesc.sel = SEL_PAIR_D0;
      OFS_PAIR_D1: bus_wdesc.sel = SEL_PAIR_D1;
      OFS_PAIR_A:  bus_wdesc.sel = SEL_PAIR_A;
      OFS_VECTAB: begin
        bus_vec_wr = 1'b1;
        bus_rdata  = {12'h000, vectab_ff};
      end
      OFS_PC: begin
        bus_pc_wr = 1'b1;
        bus_rdata = {12'h000, pc_ff};
      end
      OFS_USR_SP: begin
        bus_usr_sp_wr = 1'b1;
        bus_rdata     = {16'h0000, usr_sp_ff};
      end
      OFS_INT_SP: begin
        bus_int_sp_wr = 1'b1;
        bus_rdata     = {16'h0000, int_sp_ff};
      end
      OFS_FLAGS: begin
        bus_flg_wr = 1'b1;
        bus_rdata  = {21'h000000, flags_ff};
      end
      default: bus_hit = 1'b0;
    endcase
    if (bus_wdesc.sel != SEL_NONE) begin
      bus_rdata = read_sel(bus_wdesc.sel, bank);
    end
    if (bus_wdesc.sel inside {SEL_PAIR_D0, SEL_PAIR_D1, SEL_PAIR_A}) begin
      bus_wdesc.lanes = 2'b11;
    end
    if (!bus_wr) begin
      bus_wdesc.sel = SEL_NONE;
      bus_flg_wr    = 1'b0;
      bus_usr_sp_wr = 1'b0;
      bus_int_sp_wr = 1'b0;
      bus_vec_wr    = 1'b0;
      bus_pc_wr     = 1'b0;
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= bus_req && bus_hit;
      err_ff   <= bus_req && !bus_hit;
      rdata_ff <= bus_req ? bus_rdata : rdata_ff;
    end
  end

  // ****************************************************************
  // General registers, banked except static base; datapath write wins over bus write
  // ****************************************************************
  always_ff @(posedge CLK) begin
    reg_wr_t w;
    w = (REG_WR.sel != SEL_NONE) ? REG_WR : bus_wdesc;
    if (SYS_RST) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < 4; i++) data_ff[b][i] <= REG_RESET;
        addr_ff[b][0] <= REG_RESET;
        addr_ff[b][1] <= REG_RESET;
        frame_ff[b]   <= REG_RESET;
      end
      static_ff <= REG_RESET;
    end else begin
      case (w.sel)
        SEL_D0:      data_ff[bank][0] <= merge16(data_ff[bank][0], w.data[15:0], w.lanes);
        SEL_D1:      data_ff[bank][1] <= merge16(data_ff[bank][1], w.data[15:0], w.lanes);
        SEL_D2:      data_ff[bank][2] <= merge16(data_ff[bank][2], w.data[15:0], w.lanes);
        SEL_D3:      data_ff[bank][3] <= merge16(data_ff[bank][3], w.data[15:0], w.lanes);
        SEL_AD0:     addr_ff[bank][0] <= merge16(addr_ff[bank][0], w.data[15:0], w.lanes);
        SEL_AD1:     addr_ff[bank][1] <= merge16(addr_ff[bank][1], w.data[15:0], w.lanes);
        SEL_FRAME:   frame_ff[bank]   <= merge16(frame_ff[bank], w.data[15:0], w.lanes);
        SEL_STATIC:  static_ff        <= merge16(static_ff, w.data[15:0], w.lanes);
        SEL_PAIR_D0: begin
          data_ff[bank][2] <= w.data[31:16];
          data_ff[bank][0] <= w.data[15:0];
        end
        SEL_PAIR_D1: begin
          data_ff[bank][3] <= w.data[31:16];
          data_ff[bank][1] <= w.data[15:0];
        end
        SEL_PAIR_A: begin
          addr_ff[bank][1] <= w.data[31:16];
          addr_ff[bank][0] <= w.data[15:0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Stack pointers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      usr_sp_ff <= REG_RESET;
      int_sp_ff <= REG_RESET;
    end else if (REG_WR.sel == SEL_SP) begin
      if (flags_ff[FL_USEL]) usr_sp_ff <= merge16(usr_sp_ff, REG_WR.data[15:0], REG_WR.lanes);
      else int_sp_ff <= merge16(int_sp_ff, REG_WR.data[15:0], REG_WR.lanes);
    end else begin
      if (bus_wdesc.sel == SEL_SP && flags_ff[FL_USEL]) usr_sp_ff <= bus_wdesc.data[15:0];
      else if (bus_wdesc.sel == SEL_SP || bus_int_sp_wr) int_sp_ff <= bus_wdesc.data[15:0];
      if (bus_usr_sp_wr) usr_sp_ff <= bus_wdesc.data[15:0];
    end
  end

  // ****************************************************************
  // Vector table base and program counter
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      vectab_ff <= LONG_RESET;
      pc_ff     <= LONG_RESET;
    end else begin
      if (bus_vec_wr) vectab_ff <= bus_wdesc.data[19:0];
      if (PC_LOAD) pc_ff <= PC_NEXT;
      else if (bus_pc_wr) pc_ff <= bus_wdesc.data[19:0];
    end
  end

  // ****************************************************************
  // Flag register
  // ****************************************************************
  always_ff @(posedge CLK) begin
    logic [31:0] res;
    res = ALU_FLAGS.wide ? ALU_FLAGS.result : {16'h0000, ALU_FLAGS.result[15:0]};
    if (SYS_RST) begin
      flags_ff <= FLG_RESET;
    end else if (IRQ_ACCEPT.hw_accept || IRQ_ACCEPT.sw_accept) begin
      flags_ff[FL_IEN] <= 1'b0;
      if (IRQ_ACCEPT.hw_accept || IRQ_ACCEPT.sw_num <= SWI_LOW_LAST) begin
        flags_ff[FL_USEL] <= 1'b0;
      end
      if (IRQ_ACCEPT.hw_accept) flags_ff[FL_PRI+:PRI_W] <= IRQ_ACCEPT.new_pri;
    end else if (bus_flg_wr) begin
      // Debug and reserved bits are stored as written; software keeps them zero
      flags_ff <= bus_wdesc.data[FLG_W-1:0] & FLG_WMASK;
    end else begin
      // Only flags the operation names change
      if (ALU_FLAGS.upd_c) flags_ff[FL_CARRY] <= ALU_FLAGS.c;
      if (ALU_FLAGS.upd_z) flags_ff[FL_ZERO] <= (res == 32'h0000_0000);
      if (ALU_FLAGS.upd_s) flags_ff[FL_SIGN] <= ALU_FLAGS.wide ? res[31] : res[15];
      if (ALU_FLAGS.upd_o) flags_ff[FL_OVF] <= ALU_FLAGS.o;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    IRQ_ENABLED = IRQ_REQ && (IRQ_PRI > flags_ff[FL_PRI+:PRI_W])
                  && (!IRQ_MASKABLE || flags_ff[FL_IEN]);
  end

  assign REG_RD_DATA  = read_sel(REG_RD_SEL, bank);
  assign FRAME_BASE   = frame_ff[bank];
  assign STATIC_BASE  = static_ff;
  assign STACK_PTR    = flags_ff[FL_USEL] ? usr_sp_ff : int_sp_ff;
  assign VECTOR_BASE  = vectab_ff;
  assign PROG_COUNTER = pc_ff;
  assign STATUS_FLAGS = flags_ff;
  assign WB_ACK_O     = ack_ff;
  assign WB_ERR_O     = err_ff;
  assign WB_DAT_O     = rdata_ff;

endmodule
`default_nettype wire

// ==== tb/cpu_register_set_props.sv ====
`default_nettype none
module cpu_register_set_props
  import cpu_regs_pkg::*;
(
  // Clock and reset
  input wire logic                      CLK,
  input wire logic                      SYS_RST,
  // Bus
  input wire logic                      WB_CYC_I,
  input wire logic                      WB_STB_I,
  input wire logic                      WB_WE_I,
  input wire logic [7:0]                WB_ADR_I,
  input wire logic                      WB_ACK_O,
  input wire logic                      WB_ERR_O,
  // Datapath and interrupts
  input wire cpu_regs_pkg::alu_flags_t  ALU_FLAGS,
  input wire logic                      PC_LOAD,
  input wire logic [19:0]               PC_NEXT,
  input wire cpu_regs_pkg::irq_accept_t IRQ_ACCEPT,
  input wire logic                      IRQ_REQ,
  input wire logic                      IRQ_MASKABLE,
  input wire logic [2:0]                IRQ_PRI,
  input wire logic                      IRQ_ENABLED,
  input wire logic [19:0]               PROG_COUNTER,
  input wire logic [FLG_W-1:0]          STATUS_FLAGS
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic taken;
  logic quiet;
  logic zres;
  logic sres;
  assign taken = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  // Flag updates from the ALU lose to bus flag writes and acceptance
  assign quiet = !(taken && WB_WE_I && WB_ADR_I == OFS_FLAGS) && !IRQ_ACCEPT.hw_accept && !IRQ_ACCEPT.sw_accept;
  assign zres  = ALU_FLAGS.wide ? (ALU_FLAGS.result == 32'h0) : (ALU_FLAGS.result[15:0] == 16'h0);
  assign sres  = ALU_FLAGS.wide ? ALU_FLAGS.result[31] : ALU_FLAGS.result[15];

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ****************************************************************
  // Properties
  // ****************************************************************
  bus_answer_a: assert property (taken |=> (WB_ACK_O ^ WB_ERR_O) ##1 !(WB_ACK_O || WB_ERR_O))
    else $error("bus answer missing or too long");
  carry_capture_a: assert property (ALU_FLAGS.upd_c && quiet |=> STATUS_FLAGS[FL_CARRY] == $past(ALU_FLAGS.c))
    else $error("carry flag not captured");
  zero_flag_a: assert property (ALU_FLAGS.upd_z && quiet |=> STATUS_FLAGS[FL_ZERO] == $past(zres))
    else $error("zero flag wrong");
  sign_flag_a: assert property (ALU_FLAGS.upd_s && quiet |=> STATUS_FLAGS[FL_SIGN] == $past(sres))
    else $error("sign flag wrong");
  ovf_flag_a: assert property (ALU_FLAGS.upd_o && quiet |=> STATUS_FLAGS[FL_OVF] == $past(ALU_FLAGS.o))
    else $error("overflow flag wrong");
  zero_hold_a: assert property (!ALU_FLAGS.upd_z && quiet |=> $stable(STATUS_FLAGS[FL_ZERO]))
    else $error("zero flag changed without update");
  accept_clear_a: assert property (IRQ_ACCEPT.hw_accept || IRQ_ACCEPT.sw_accept |=> !STATUS_FLAGS[FL_IEN])
    else $error("enable flag not cleared at accept");
  stack_sel_a: assert property (IRQ_ACCEPT.hw_accept || (IRQ_ACCEPT.sw_accept && IRQ_ACCEPT.sw_num <= SWI_LOW_LAST)
    |=> !STATUS_FLAGS[FL_USEL])
    else $error("stack select not cleared");
  pri_load_a: assert property (IRQ_ACCEPT.hw_accept |=> STATUS_FLAGS[FL_PRI +: PRI_W] == $past(IRQ_ACCEPT.new_pri))
    else $error("priority level not loaded");
  irq_gate_a: assert property (IRQ_ENABLED == (IRQ_REQ && IRQ_PRI > STATUS_FLAGS[FL_PRI +: PRI_W]
    && (!IRQ_MASKABLE || STATUS_FLAGS[FL_IEN])))
    else $error("interrupt gate wrong");
  pc_load_a: assert property (PC_LOAD |=> PROG_COUNTER == $past(PC_NEXT))
    else $error("program counter not loaded");

  cover property (IRQ_ACCEPT.hw_accept);
  cover property (WB_ERR_O);
  cover property (ALU_FLAGS.upd_z && quiet);
endmodule

bind cpu_register_set cpu_register_set_props props_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .ALU_FLAGS(ALU_FLAGS),
  .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .IRQ_ACCEPT(IRQ_ACCEPT), .IRQ_REQ(IRQ_REQ),
  .IRQ_MASKABLE(IRQ_MASKABLE), .IRQ_PRI(IRQ_PRI), .IRQ_ENABLED(IRQ_ENABLED),
  .PROG_COUNTER(PROG_COUNTER), .STATUS_FLAGS(STATUS_FLAGS)
);
`default_nettype wire

// ==== tb/cpu_exec_model.sv ====
`default_nettype none
module cpu_exec_model
  import cpu_regs_pkg::*;
(
  // Clock
  input  wire logic                      clk,
  // Datapath side
  output var  cpu_regs_pkg::reg_wr_t     reg_wr,
  output var  cpu_regs_pkg::alu_flags_t  alu_flags,
  output var  logic                      pc_load,
  output var  logic [19:0]               pc_next,
  // Interrupt side
  output var  cpu_regs_pkg::irq_accept_t irq_accept,
  output var  logic                      irq_req,
  output var  logic                      irq_mask,
  output var  logic [2:0]                irq_pri
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // One-cycle strobes, then a cycle for the effect to show; request holds its levels and waits one cycle
  // ****************************************************************
  initial begin
    reg_wr = '0;
    alu_flags = '0;
    pc_load = 1'b0;
    pc_next = 20'h00000;
    irq_accept = '0;
    irq_req = 1'b0;
    irq_mask = 1'b0;
    irq_pri = 3'h0;
  end
  task automatic dp_write(input reg_sel_t s, input logic [1:0] l, input logic [31:0] d);
    reg_wr <= {s, l, d};
    @(posedge clk);
    reg_wr <= '0;
    @(posedge clk);
  endtask
  task automatic alu(input logic [3:0] upd, input logic c, input logic o, input logic [31:0] r, input logic w);
    alu_flags <= {upd, c, o, r, w};
    @(posedge clk);
    alu_flags <= '0;
    @(posedge clk);
  endtask
  task automatic load_pc(input logic [19:0] v);
    pc_load <= 1'b1;
    pc_next <= v;
    @(posedge clk);
    pc_load <= 1'b0;
    pc_next <= ~v;
    @(posedge clk);
  endtask
  task automatic accept(input logic hw, input logic sw, input logic [5:0] n, input logic [2:0] p);
    irq_accept <= {hw, sw, n, p};
    @(posedge clk);
    irq_accept <= '0;
    @(posedge clk);
  endtask
  task automatic request(input logic r, input logic m, input logic [2:0] p);
    irq_req <= r;
    irq_mask <= m;
    irq_pri <= p;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_cpu_register_set.sv ====
`default_nettype none
module tb_cpu_register_set
  import cpu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cyc, stb, we, ack, err, pc_load, irq_req, irq_mask, irq_en;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rd_data;
  logic [19:0] pc_next, vector_base, prog_counter;
  logic [15:0] frame_base, static_base, stack_ptr;
  logic [2:0] irq_pri;
  logic [FLG_W-1:0] status_flags;
  reg_wr_t reg_wr;
  reg_sel_t rd_sel;
  alu_flags_t alu_flags;
  irq_accept_t irq_accept;
  int errors, num_checks, cycles;

  cpu_register_set cpu_register_set_i (.CLK(clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .WB_ERR_O(err), .REG_WR(reg_wr), .REG_RD_SEL(rd_sel), .REG_RD_DATA(rd_data), .ALU_FLAGS(alu_flags),
    .PC_LOAD(pc_load), .PC_NEXT(pc_next), .IRQ_ACCEPT(irq_accept), .IRQ_REQ(irq_req),
    .IRQ_MASKABLE(irq_mask), .IRQ_PRI(irq_pri), .IRQ_ENABLED(irq_en), .FRAME_BASE(frame_base),
    .STATIC_BASE(static_base), .STACK_PTR(stack_ptr), .VECTOR_BASE(vector_base),
    .PROG_COUNTER(prog_counter), .STATUS_FLAGS(status_flags));
  cpu_exec_model exec_i (.clk(clk), .reg_wr(reg_wr), .alu_flags(alu_flags), .pc_load(pc_load),
    .pc_next(pc_next), .irq_accept(irq_accept), .irq_req(irq_req), .irq_mask(irq_mask), .irq_pri(irq_pri));

  // ****************************************************************
  // Clock, watchdog, checks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; starts just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q, output logic e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    q = dat_r;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic e;
    wb(1'b1, a, d, s, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    wb(1'b0, a, 32'h0, 4'hF, q, e);
    chk({31'h0, e}, {31'h0, experr});
    if (!experr) chk(q, exp);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    {cyc, stb, we, adr, sel, dat_w} = '0;
    rd_sel = SEL_NONE;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 13; i++) rd(8'(4 * i), 32'h0, 1'b0);
    rd(8'h44, 32'h0, 1'b1);
    rd(8'hFC, 32'h0, 1'b1);
    wr(OFS_DATA0, 32'h1234, 4'hF);
    wr(OFS_DATA0, 32'h00AB, 4'h1);
    rd(OFS_DATA0, 32'h12AB, 1'b0);
    wr(OFS_DATA1, 32'h1234, 4'hF);
    exec_i.dp_write(SEL_D1, 2'b10, 32'h0000_AB00);
    rd(OFS_DATA1, 32'hAB34, 1'b0);
    wr(OFS_PAIR_D0, 32'h1111_2222, 4'hF);
    rd(OFS_DATA2, 32'h1111, 1'b0);
    rd(OFS_DATA0, 32'h2222, 1'b0);
    rd_sel <= SEL_PAIR_D0;
    @(posedge clk);
    chk(rd_data, 32'h1111_2222);
    wr(OFS_PAIR_A, 32'hA1A1_A0A0, 4'hF);
    rd(OFS_ADDR1, 32'hA1A1, 1'b0);
    rd(OFS_ADDR0, 32'hA0A0, 1'b0);
    wr(OFS_FRAME, 32'h0F0F, 4'hF);
    wr(OFS_FLAGS, 32'h010, 4'hF);
    rd(OFS_DATA0, 32'h0, 1'b0);
    wr(OFS_FRAME, 32'h7777, 4'hF);
    chk({16'h0, frame_base}, 32'h7777);
    wr(OFS_FLAGS, 32'h000, 4'hF);
    rd(OFS_DATA0, 32'h2222, 1'b0);
    chk({16'h0, frame_base}, 32'h0F0F);
    wr(OFS_USR_SP, 32'h1111, 4'hF);
    wr(OFS_INT_SP, 32'h2222, 4'hF);
    chk({16'h0, stack_ptr}, 32'h2222);
    wr(OFS_FLAGS, 32'h080, 4'hF);
    chk({16'h0, stack_ptr}, 32'h1111);
    rd(OFS_STACK, 32'h1111, 1'b0);
    wr(OFS_VECTAB, 32'hF_FFFF, 4'hF);
    chk({12'h0, vector_base}, 32'hF_FFFF);
    wr(OFS_STATIC, 32'hBEEF, 4'hF);
    chk({16'h0, static_base}, 32'hBEEF);
    exec_i.load_pc(20'hABCDE);
    chk({12'h0, prog_counter}, 32'hA_BCDE);
    wr(OFS_FLAGS, 32'h000, 4'hF);
    exec_i.alu(4'hF, 1'b1, 1'b1, 32'h0001_0000, 1'b0);
    chk({21'h0, status_flags}, 32'h025);
    exec_i.alu(4'h6, 1'b0, 1'b0, 32'h8000_0000, 1'b1);
    chk({21'h0, status_flags}, 32'h029);
    exec_i.alu(4'h9, 1'b0, 1'b0, 32'h0, 1'b1);
    chk({21'h0, status_flags}, 32'h008);
    wr(OFS_FLAGS, 32'h3C0, 4'hF);
    exec_i.request(1'b1, 1'b1, 3'd3);
    chk({31'h0, irq_en}, 32'h0);
    exec_i.request(1'b1, 1'b1, 3'd4);
    chk({31'h0, irq_en}, 32'h1);
    wr(OFS_FLAGS, 32'h380, 4'hF);
    chk({31'h0, irq_en}, 32'h0);
    exec_i.request(1'b1, 1'b0, 3'd4);
    chk({31'h0, irq_en}, 32'h1);
    exec_i.request(1'b0, 1'b0, 3'd0);
    wr(OFS_FLAGS, 32'h3C0, 4'hF);
    exec_i.accept(1'b1, 1'b0, 6'd0, 3'd7);
    chk({21'h0, status_flags}, 32'h700);
    wr(OFS_FLAGS, 32'h0C0, 4'hF);
    exec_i.accept(1'b0, 1'b1, 6'd32, 3'd0);
    chk({21'h0, status_flags}, 32'h080);
    exec_i.accept(1'b0, 1'b1, 6'd31, 3'd0);
    chk({21'h0, status_flags}, 32'h000);
    end_sim();
  end
endmodule
`default_nettype wire
